/* logic/fetch_pkg.sv */
// Constants, types and states shared by the instruction fetch path
package fetch_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int GAP_NS = 80;
    localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_CYC = 2;
    localparam int NARROW_FILL_EXTRA = 2;
    localparam int CACHE_BYTES = 16384;
    localparam int WAYS = 2;
    localparam int LINE_HW = 8;
    localparam int LINE_BYTES = LINE_HW * 2;
    localparam int SETS = CACHE_BYTES / (WAYS * LINE_BYTES);
    localparam int TLB_N = 8;
    localparam int SEC_LSB = 20;
    localparam int TABLE_LSB = 14;
    localparam logic [3:0] BEATS_FILL = 4'h8;
    localparam logic [3:0] BEATS_WIDE = 4'h2;
    localparam logic [3:0] BEATS_NARROW = 4'h1;
    localparam logic [3:0] BEATS_DESC = 4'h2;

    typedef enum {S_IDLE, S_WALK, S_MEM, S_EXTRA, S_PUSH} state_e;

    typedef struct packed {
        logic valid;
        logic [11:0] vsec;
        logic [11:0] psec;
    } tlb_entry_s;

    typedef struct packed {
        logic [31:0] data;
        logic narrow;
    } fetch_rsp_s;

    typedef struct packed {
        logic cs_b;
        logic oe_b;
        logic [30:0] addr;
    } sram_cmd_s;
endpackage

/* logic/instr_fetch_sram_path.sv */
// Instruction fetch path: cache, lookaside buffers, SRAM burst engine
// How it works
// - Wide fetch uncached: two reads per select
// - Uncached wide fetches separated by fixed gap
// - Miss fills line with eight reads, one select
// - With cache, gap only after line fills and table walk reads
// - Narrow fetch uncached: one read per select
// - Narrow uncached: gap after every read
// - Cache hit answers in one cycle, no memory
// - Narrow mode fill takes two cycles longer
// - Lookaside buffers keep recent section mappings
// - Buffer hit adds no first-read latency
// - Buffer miss fetches mapping from table first
// - Cache holds sixteen kilobytes
// - Cache is two-way set associative
`timescale 1ns/1ps
module instr_fetch_sram_path #(
    parameter int SETS = fetch_pkg::SETS,
    parameter int TLB_N = fetch_pkg::TLB_N,
    parameter int RD_CYC = fetch_pkg::RD_CYC,
    parameter int GAP_CYC = fetch_pkg::GAP_CYC
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // Mode
    input wire logic cache_en,
    input wire logic narrow_mode,
    input wire logic xlate_en,
    input wire logic [31:0] table_base,
    // Core fetch request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [31:0] req_addr,
    // Core fetch answer
    output logic rsp_valid,
    input wire logic rsp_ready,
    output fetch_pkg::fetch_rsp_s rsp,
    // External memory
    output fetch_pkg::sram_cmd_s sram_cmd,
    input wire logic [15:0] sram_rdata
);
    localparam int IW = $clog2(SETS);
    localparam int TW = 28 - IW;
    localparam int TIW = $clog2(TLB_N);
    localparam logic [7:0] RD_LAST = 8'(RD_CYC - 1);
    localparam logic [7:0] GAP_LD = 8'(GAP_CYC);
    localparam logic [1:0] EXTRA_LD = 2'(fetch_pkg::NARROW_FILL_EXTRA);

    if (SETS < 2 || (SETS & (SETS - 1)) != 0 || SETS > 65536 ||
        TLB_N < 2 || (TLB_N & (TLB_N - 1)) != 0 ||
        RD_CYC < 1 || RD_CYC > 255 || GAP_CYC < 1 || GAP_CYC > 255)
    begin : g_bad
        $error("instr_fetch_sram_path: unsupported parameters");
    end

    function automatic logic [31:0] pick(input logic [7:0][15:0] l,
        input logic [2:0] o, input logic n);
        if (n)
            pick = {16'h0000, l[o]};
        else
            pick = {l[{o[2:1], 1'b1}], l[{o[2:1], 1'b0}]};
    endfunction

    // Burst start address (halfwords) and beat count
    function automatic logic [34:0] setup(input logic [11:0] ps,
        input logic [31:0] va, input logic fill, input logic n);
        if (fill)
            setup = {ps, va[19:4], 3'b000, fetch_pkg::BEATS_FILL};
        else if (n)
            setup = {ps, va[19:1], fetch_pkg::BEATS_NARROW};
        else
            setup = {ps, va[19:2], 1'b0, fetch_pkg::BEATS_WIDE};
    endfunction

    fetch_pkg::state_e st_q, st_d;
    logic [31:0] va_q, va_d;
    logic [11:0] psec_q, psec_d;
    logic fill_q, fill_d, narrow_q, narrow_d;
    logic act_q, act_d;
    logic [30:0] addr_q, addr_d;
    logic [7:0] cyc_q, cyc_d, gap_q, gap_d;
    logic [2:0] idx_q, idx_d;
    logic [3:0] nbeat_q, nbeat_d;
    logic [1:0] ext_q, ext_d;
    logic [7:0][15:0] hw_q, hw_d;
    logic burst_done, push, line_we, lru_we, tlb_we;
    fetch_pkg::fetch_rsp_s push_data;

    // Lookaside buffers
    fetch_pkg::tlb_entry_s tlb_q [TLB_N];
    logic [TIW-1:0] rr_q;
    logic tlb_ok;
    logic [11:0] phys_sec;

    // Cache storage
    logic [127:0] data_q [2][SETS];
    logic [TW-1:0] tag_q [2][SETS];
    logic [1:0][SETS-1:0] valid_q;
    logic [SETS-1:0] lru_q;
    logic [31:0] pa;
    logic [IW-1:0] set_r, set_f;
    logic c_hit, hit_way, victim;
    logic [127:0] hit_line;

    // Answer buffer
    fetch_pkg::fetch_rsp_s buf_q [2];
    logic [1:0] cnt_q;
    logic wr_q, rd_q, buf_ready, pop;

    always_comb
    begin
        tlb_ok = !xlate_en;
        phys_sec = req_addr[31:20];
        for (int i = 0; i < TLB_N; i++)
        begin
            if (xlate_en && tlb_q[i].valid &&
                tlb_q[i].vsec == req_addr[31:20])
            begin
                tlb_ok = 1'b1;
                phys_sec = tlb_q[i].psec;
            end
        end
    end

    assign pa = {phys_sec, req_addr[19:0]};
    assign set_r = pa[4 +: IW];
    assign set_f = va_q[4 +: IW];

    always_comb
    begin
        c_hit = 1'b0;
        hit_way = 1'b0;
        for (int w = 0; w < 2; w++)
        begin
            if (valid_q[w][set_r] && tag_q[w][set_r] == pa[31 -: TW])
            begin
                c_hit = 1'b1;
                hit_way = 1'(w);
            end
        end
        hit_line = data_q[hit_way][set_r];
        if (!valid_q[0][set_f])
            victim = 1'b0;
        else if (!valid_q[1][set_f])
            victim = 1'b1;
        else
            victim = lru_q[set_f];
    end

    assign buf_ready = cnt_q != 2'h2;
    assign pop = ce && rsp_valid && rsp_ready;
    assign rsp_valid = cnt_q != 2'h0;
    assign rsp = buf_q[rd_q];
    assign sram_cmd = {!act_q, !act_q, addr_q};

    always_comb
    begin
        st_d = st_q;
        va_d = va_q;
        psec_d = psec_q;
        fill_d = fill_q;
        narrow_d = narrow_q;
        act_d = act_q;
        addr_d = addr_q;
        cyc_d = cyc_q;
        idx_d = idx_q;
        nbeat_d = nbeat_q;
        hw_d = hw_q;
        gap_d = gap_q;
        ext_d = ext_q;
        burst_done = 1'b0;
        push = 1'b0;
        push_data = '0;
        line_we = 1'b0;
        lru_we = 1'b0;
        tlb_we = 1'b0;
        req_ready = 1'b0;
        if (gap_q != 8'h00)
            gap_d = gap_q - 8'h01;
        if (act_q)
        begin
            if (cyc_q == RD_LAST)
            begin
                hw_d[idx_q] = sram_rdata;
                cyc_d = 8'h00;
                addr_d = addr_q + 31'h00000001;
                if ({1'b0, idx_q} == nbeat_q - 4'h1)
                begin
                    // Select drops after the last beat; gap starts here
                    act_d = 1'b0;
                    gap_d = GAP_LD;
                    burst_done = 1'b1;
                end
                else
                    idx_d = idx_q + 3'h1;
            end
            else
                cyc_d = cyc_q + 8'h01;
        end
        else if ((st_q == fetch_pkg::S_WALK || st_q == fetch_pkg::S_MEM) &&
                 gap_q == 8'h00)
        begin
            act_d = 1'b1;
            idx_d = 3'h0;
            cyc_d = 8'h00;
        end
        case (st_q)
            fetch_pkg::S_IDLE:
            begin
                req_ready = ce && buf_ready;
                if (req_valid && buf_ready)
                begin
                    va_d = req_addr;
                    fill_d = cache_en;
                    narrow_d = narrow_mode;
                    if (tlb_ok && cache_en && c_hit)
                    begin
                        push = 1'b1;
                        push_data = {pick(hit_line, req_addr[3:1],
                            narrow_mode), narrow_mode};
                        lru_we = 1'b1;
                    end
                    else if (!tlb_ok)
                    begin
                        st_d = fetch_pkg::S_WALK;
                        addr_d = {table_base[31:fetch_pkg::TABLE_LSB],
                            req_addr[31:20], 1'b0};
                        nbeat_d = fetch_pkg::BEATS_DESC;
                    end
                    else
                    begin
                        psec_d = phys_sec;
                        st_d = fetch_pkg::S_MEM;
                        {addr_d, nbeat_d} = setup(phys_sec, req_addr,
                            cache_en, narrow_mode);
                    end
                end
            end
            fetch_pkg::S_WALK:
            begin
                if (burst_done)
                begin
                    tlb_we = 1'b1;
                    psec_d = sram_rdata[15:4];
                    st_d = fetch_pkg::S_MEM;
                    {addr_d, nbeat_d} = setup(sram_rdata[15:4], va_q,
                        fill_q, narrow_q);
                end
            end
            fetch_pkg::S_MEM:
            begin
                if (burst_done)
                begin
                    line_we = fill_q;
                    if (fill_q && narrow_q)
                    begin
                        st_d = fetch_pkg::S_EXTRA;
                        ext_d = EXTRA_LD;
                    end
                    else
                        st_d = fetch_pkg::S_PUSH;
                end
            end
            fetch_pkg::S_EXTRA:
            begin
                ext_d = ext_q - 2'h1;
                if (ext_q == 2'h1)
                    st_d = fetch_pkg::S_PUSH;
            end
            fetch_pkg::S_PUSH:
            begin
                if (buf_ready)
                begin
                    push = 1'b1;
                    push_data = {pick(hw_q, fill_q ? va_q[3:1] : 3'h0,
                        narrow_q), narrow_q};
                    st_d = fetch_pkg::S_IDLE;
                end
            end
            default:
                st_d = fetch_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            st_q <= fetch_pkg::S_IDLE;
            va_q <= 32'h00000000;
            psec_q <= 12'h000;
            fill_q <= 1'b0;
            narrow_q <= 1'b0;
            act_q <= 1'b0;
            addr_q <= 31'h00000000;
            cyc_q <= 8'h00;
            idx_q <= 3'h0;
            nbeat_q <= 4'h0;
            hw_q <= '0;
            gap_q <= 8'h00;
            ext_q <= 2'h0;
        end
        else if (ce)
        begin
            st_q <= st_d;
            va_q <= va_d;
            psec_q <= psec_d;
            fill_q <= fill_d;
            narrow_q <= narrow_d;
            act_q <= act_d;
            addr_q <= addr_d;
            cyc_q <= cyc_d;
            idx_q <= idx_d;
            nbeat_q <= nbeat_d;
            hw_q <= hw_d;
            gap_q <= gap_d;
            ext_q <= ext_d;
        end
    end

    // Round-robin refill keeps the most recent sections
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            rr_q <= '0;
            for (int i = 0; i < TLB_N; i++)
                tlb_q[i] <= '0;
        end
        else if (ce && tlb_we)
        begin
            tlb_q[rr_q] <= {1'b1, va_q[31:20], psec_d};
            rr_q <= rr_q + 1'b1;
        end
    end

    // Arrays sized SETS x 2 ways x 16 bytes
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            valid_q <= '0;
            lru_q <= '0;
        end
        else if (ce)
        begin
            if (line_we)
            begin
                data_q[victim][set_f] <= hw_d;
                tag_q[victim][set_f] <= {psec_q, va_q[19:4+IW]};
                valid_q[victim][set_f] <= 1'b1;
                lru_q[set_f] <= !victim;
            end
            if (lru_we)
                lru_q[set_r] <= !hit_way;
        end
    end

    // Two entries so a stalled core loses no word
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            cnt_q <= 2'h0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            buf_q[0] <= '0;
            buf_q[1] <= '0;
        end
        else if (ce)
        begin
            if (push)
            begin
                buf_q[wr_q] <= push_data;
                wr_q <= !wr_q;
            end
            if (pop)
                rd_q <= !rd_q;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

/* bench/sram_model.sv */
// Asynchronous 16-bit SRAM model on the far side of the fetch path
`timescale 1ns/1ps
module sram_model (
    // Clock
    input wire logic clk,
    // Memory side
    input fetch_pkg::sram_cmd_s sram_cmd,
    output logic [15:0] sram_rdata
);
    logic [15:0] last_q = 16'h0;
    logic drv;
    assign drv = !sram_cmd.cs_b && !sram_cmd.oe_b;
    // Every address answers, so a table anywhere reads back
    assign sram_rdata = drv ? sram_cmd.addr[15:0] ^ sram_cmd.addr[30:15]
        ^ 16'h5A3C : ~last_q;
    // Released bus shows the inverse, never a stale word
    always_ff @(posedge clk)
        if (drv)
            last_q <= sram_rdata;
endmodule

/* bench/fetch_path_monitor.sv */
// Port checker for the fetch path, bound to its top module
`timescale 1ns/1ps
module fetch_path_monitor #(
    parameter int RD_CYC = 2,
    parameter int GAP_CYC = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Core side
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input fetch_pkg::fetch_rsp_s rsp,
    // Memory side
    input fetch_pkg::sram_cmd_s sram_cmd
);
    logic [7:0] cyc_q;
    logic [7:0] cyc_d;
    logic [30:0] start_q;
    logic [30:0] start_d;
    always_comb
    begin
        cyc_d = sram_cmd.cs_b ? 8'h00 : cyc_q + 8'h01;
        start_d = (cyc_q == 8'h00) ? sram_cmd.addr : start_q;
    end
    always_ff @(posedge clk)
    begin
        cyc_q <= rst_b ? cyc_d : 8'h00;
        start_q <= start_d;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence burst_end; $rose(sram_cmd.cs_b); endsequence
    // Gap fixed at eight cycles, the default of GAP_CYC
    sequence gap_hold; sram_cmd.cs_b [*8]; endsequence
    a_gap_after_burst: assert property (burst_end |-> gap_hold)
        else $error("select fell again inside the gap");
    a_cs_oe_pair: assert property (sram_cmd.cs_b == sram_cmd.oe_b)
        else $error("select and output enable differ");
    a_addr_step: assert property (!sram_cmd.cs_b && !$past(sram_cmd.cs_b)
        && sram_cmd.addr != $past(sram_cmd.addr)
        |-> sram_cmd.addr == $past(sram_cmd.addr) + 31'h1)
        else $error("burst address did not step by one");
    a_burst_len: assert property (burst_end |-> cyc_q == RD_CYC
        || cyc_q == 2 * RD_CYC || cyc_q == 8 * RD_CYC)
        else $error("burst length not one, two or eight beats");
    a_fill_aligned: assert property ((burst_end and cyc_q == 8 * RD_CYC)
        |-> start_q[2:0] == 3'h0)
        else $error("line fill not aligned");
    a_rsp_hold: assert property (rsp_valid && !rsp_ready
        |=> rsp_valid && $stable(rsp))
        else $error("answer dropped before pop");
    a_busy_refuse: assert property (!sram_cmd.cs_b |-> !req_ready)
        else $error("request accepted during burst");
    a_narrow_upper: assert property (rsp_valid && rsp.narrow
        |-> rsp.data[31:16] == 16'h0)
        else $error("narrow answer upper half not zero");
endmodule
bind instr_fetch_sram_path fetch_path_monitor #(.RD_CYC(RD_CYC),
    .GAP_CYC(GAP_CYC)) mon (.clk(clk), .rst_b(rst_b), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp),
    .sram_cmd(sram_cmd));

/* bench/instr_fetch_sram_path_tb.sv */
// Self-checking bench for the instruction fetch path
`timescale 1ns/1ps
module instr_fetch_sram_path_tb;
    logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, cache_en = 1'b0;
    logic narrow_mode = 1'b0, xlate_en = 1'b0, req_valid = 1'b0;
    logic rsp_ready = 1'b1, stall = 1'b0, req_ready, rsp_valid;
    logic [31:0] table_base = 32'h0, req_addr = 32'h0, va;
    logic [15:0] sram_rdata;
    fetch_pkg::fetch_rsp_s rsp, expq[$];
    fetch_pkg::sram_cmd_s sram_cmd;
    int num_errors = 0, compares = 0, seed = 32'h0103FA08, l0, lw, lat, n;
    initial forever #5 clk = ~clk;
    instr_fetch_sram_path dut (.clk(clk), .rst_b(rst_b), .ce(ce),
        .cache_en(cache_en), .narrow_mode(narrow_mode), .xlate_en(xlate_en),
        .table_base(table_base), .req_valid(req_valid),
        .req_ready(req_ready), .req_addr(req_addr), .rsp_valid(rsp_valid),
        .rsp_ready(rsp_ready), .rsp(rsp), .sram_cmd(sram_cmd),
        .sram_rdata(sram_rdata));
    sram_model mem (.clk(clk), .sram_cmd(sram_cmd), .sram_rdata(sram_rdata));
    function automatic logic [15:0] f(input logic [30:0] a);
        return a[15:0] ^ a[30:15] ^ 16'h5A3C;
    endfunction
    function automatic fetch_pkg::fetch_rsp_s ex(input logic [30:0] a,
        input logic nm);
        return {nm ? {16'h0, f(a)} : {f(a + 31'h1), f(a)}, nm};
    endfunction
    task automatic end_of_test;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp_val(input string s, input logic [32:0] e,
        input logic [32:0] g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("Error %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic cmp_int(input string s, input int e, input int g);
        cmp_val(s, e, g);
    endtask
    // Latency: edges from the taking edge to the edge that pops the answer
    task automatic fetch(input logic [31:0] v, input logic nm, input int pre,
        output int lt);
        logic [15:0] w;
        int k;
        repeat (pre) @(posedge clk);
        w = f({table_base[31:14], v[31:20], 1'b1});
        req_valid <= 1'b1;
        req_addr <= v;
        narrow_mode <= nm;
        @(posedge clk);
        for (k = 0; k < 200 && req_ready !== 1'b1; k++)
            @(posedge clk);
        expq.push_back(ex({xlate_en ? w[15:4] : v[31:20], v[19:2],
            nm & v[1]}, nm));
        req_valid <= 1'b0;
        // A hit stands only until the next edge pops it, so look now
        lt = 1;
        #1;
        while (lt < 200 && rsp_valid !== 1'b1)
        begin
            @(posedge clk);
            #1;
            lt++;
        end
        // Return on the popping edge so callers drive on an edge
        @(posedge clk);
        if (k == 200 || lt == 200)
        begin
            num_errors++;
            end_of_test;
        end
    endtask
    always @(posedge clk)
        rsp_ready <= !stall;
    always @(posedge clk)
        if (rst_b && ce && rsp_valid === 1'b1 && rsp_ready)
            cmp_val("rsp", expq.size() > 0 ? expq.pop_front() : ~rsp, rsp);
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_of_test;
    end
    initial
    begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        // Back-to-back fetches press on the gap after each burst
        for (n = 0; n < 8; n++)
        begin
            fetch($random(seed), n / 4, n % 4 ? 1 : 10, lat);
            if (n == 0)
                l0 = lat;
            // Pressed fetch is taken four edges after the last burst ends
            if (n == 3)
                cmp_int("gap lat", l0 + fetch_pkg::GAP_CYC - 4, lat);
            if (n == 4)
            begin
                lw = lat;
                cmp_int("narrow lat", l0 - fetch_pkg::RD_CYC, lw);
            end
        end
        cmp_int("narrow gap", lw + fetch_pkg::GAP_CYC - 4, lat);
        cache_en <= 1'b1;
        va = $random(seed) & 32'hFFFFFFF0;
        fetch(va, 1'b0, 10, lw);
        cmp_int("fill lat", l0 + 6 * fetch_pkg::RD_CYC, lw);
        fetch(va + 32'h4, 1'b0, 10, lat);
        cmp_int("hit lat", 1, lat);
        fetch(va + 32'h40, 1'b1, 10, lat);
        cmp_int("narrow fill", lw + 2, lat);
        fetch(va ^ 32'h2000, 1'b0, 10, lat);
        fetch(va, 1'b0, 10, lat);
        cmp_int("way0 hit", 1, lat);
        fetch(va ^ 32'h2000, 1'b0, 10, lat);
        cmp_int("way1 hit", 1, lat);
        // Stalled receiver: two hits fill the buffer, then refusal
        stall <= 1'b1;
        req_valid <= 1'b1;
        req_addr <= va;
        narrow_mode <= 1'b0;
        n = 0;
        repeat (8)
        begin
            @(posedge clk);
            if (req_ready === 1'b1 && n < 9)
            begin
                n++;
                expq.push_back(ex({va[31:2], 1'b0}, 1'b0));
            end
        end
        req_valid <= 1'b0;
        cmp_int("buffer takes", 2, n);
        stall <= 1'b0;
        ce <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        cmp_val("ready ce", 33'h0, req_ready);
        @(posedge clk);
        ce <= 1'b1;
        cache_en <= 1'b0;
        xlate_en <= 1'b1;
        table_base <= $random(seed) & 32'hFFFFC000;
        va = $random(seed);
        fetch(va, 1'b0, 10, lat);
        cmp_int("walk lat", 1, lat > l0);
        fetch(va ^ 32'h4, 1'b0, 10, lat);
        cmp_int("mapped lat", l0, lat);
        fetch(va ^ 32'h00100000, 1'b0, 10, lat);
        fetch(va ^ 32'h8, 1'b0, 10, lat);
        cmp_int("kept lat", l0, lat);
        repeat (20) @(posedge clk);
        cmp_int("queue left", 0, expq.size());
        end_of_test;
    end
endmodule
